// ==== hw/lpi_device.sv ====
// Device-side command, deep power-down, read latency and write mask logic
// Functional notes
// - Deep power-down entry wipes the whole array
// - Latency three: first data two clocks later
// - Data changes only with its strobe
// - Masks affect writes only, never reads
// - Mask sampled per strobe edge, zero latency
// - Mask lane i covers data byte i
// - Deep power-down also loses both mode registers
// - Mode set with bank two loads extended
`default_nettype none
module lpi_device
    import lpi_pkg::*;
#(
    parameter int MEM_WORDS = 16
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // Command bus
    input  wire logic                cke,
    input  wire logic                cs_n,
    input  wire logic                ras_n,
    input  wire logic                cas_n,
    input  wire logic                we_n,
    input  wire logic [1:0]          ba,
    input  wire logic [ADDR_W-1:0]   addr,
    // Write data, rising and falling strobe beats
    input  wire logic [DATA_W-1:0]   wdata_rise,
    input  wire logic [DATA_W-1:0]   wdata_fall,
    input  wire logic [LANES-1:0]    dm_rise,
    input  wire logic [LANES-1:0]    dm_fall,
    // Read data, rising and falling strobe beats
    output logic      [DATA_W-1:0]   dq_rise,
    output logic      [DATA_W-1:0]   dq_fall,
    output logic                     dq_oe,
    output logic                     dqs_oe,
    // Status
    output logic                     deep_power_down,
    output logic                     initialized,
    output logic      [MR_CL_W-1:0]  read_latency_setting
);
    localparam int COL_W = $clog2(MEM_WORDS);

    // Whole module state
    typedef struct packed {
        lpi_state_t                            state;      // Run or deep power-down
        logic                                  cke_q;      // Clock enable last edge
        logic [ADDR_W-1:0]                     mr;         // Base mode register
        logic [ADDR_W-1:0]                     emr;        // Extended mode register
        logic                                  mr_ok;      // Base register loaded
        logic                                  emr_ok;     // Extended register loaded
        logic [1:0]                            rd_cnt;     // Read latency countdown
        logic [COL_W-1:0]                      rd_col;     // Read column
        logic                                  wr_pend;    // Write beats due this edge
        logic [COL_W-1:0]                      wr_col;     // Write column
        logic [DATA_W-1:0]                     dq_rise;    // Rising beat out
        logic [DATA_W-1:0]                     dq_fall;    // Falling beat out
        logic                                  dq_oe;      // Drive data
        logic [MEM_WORDS-1:0][DATA_W-1:0]      mem;        // Storage array
    } lpi_regs_t;

    lpi_regs_t st;       // Current state
    lpi_regs_t next_st;  // Next state

    // Decode of the command inputs
    function automatic logic [2:0] cmd_of(input logic r, input logic c, input logic w);
        return {r, c, w};
    endfunction

    logic [2:0]        cmd;       // Command code
    logic              cmd_ok;    // Chip selected with clock enable
    logic              dpd_entry; // Deep power-down command
    logic              rd_go;     // Read accepted
    logic              wr_go;     // Write accepted
    logic              mrs_go;    // Mode register set accepted
    logic [COL_W-1:0]  col;       // Column of this command
    logic [COL_W-1:0]  wcol_nx;   // Second beat column
    logic [DATA_W-1:0] mrg_rise;  // Merged rising word
    logic [DATA_W-1:0] mrg_fall;  // Merged falling word
    logic [MR_CL_W-1:0] cl;       // Read latency setting

    // Command qualification
    always_comb begin
        cmd       = cmd_of(ras_n, cas_n, we_n);
        cmd_ok    = (st.state == ST_RUN) && st.cke_q && cke && !cs_n;
        dpd_entry = (st.state == ST_RUN) && st.cke_q && !cke && !cs_n && (cmd == CMD_BST);
        rd_go     = cmd_ok && (cmd == CMD_RD);
        wr_go     = cmd_ok && (cmd == CMD_WR);
        mrs_go    = cmd_ok && (cmd == CMD_MRS);
        col       = addr[COL_W-1:0];
        wcol_nx   = COL_W'(st.wr_col + 1'b1);
        cl        = st.mr[MR_CL_LSB +: MR_CL_W];
    end

    // Write lanes; masks come with their own beat, no delay
    lpi_byte_merge #(.LANES(LANES)) u_merge_rise (
        .old_word (st.mem[st.wr_col]),
        .new_word (wdata_rise),
        .mask     (dm_rise),
        .merged   (mrg_rise)
    );
    lpi_byte_merge #(.LANES(LANES)) u_merge_fall (
        .old_word (st.mem[wcol_nx]),
        .new_word (wdata_fall),
        .mask     (dm_fall),
        .merged   (mrg_fall)
    );

    // Next-state logic
    always_comb begin
        next_st       = st;
        next_st.cke_q = cke;
        next_st.dq_oe = 1'b0;
        unique case (st.state)
            ST_RUN: begin
                if (dpd_entry) begin
                    // Array and both mode registers are lost
                    next_st.state   = ST_DPD;
                    next_st.mem     = '0;
                    next_st.mr      = MR_RST;
                    next_st.emr     = EMR_RST;
                    next_st.mr_ok   = 1'b0;
                    next_st.emr_ok  = 1'b0;
                    next_st.rd_cnt  = 2'h0;
                    next_st.wr_pend = 1'b0;
                end else begin
                    // Mode register loads by bank address
                    if (mrs_go && ba == BA_EMR) begin
                        next_st.emr    = addr;
                        next_st.emr_ok = 1'b1;
                    end else if (mrs_go && ba == BA_MR) begin
                        next_st.mr    = addr;
                        next_st.mr_ok = 1'b1;
                    end
                    // Write beats one edge after the command, mask with data
                    next_st.wr_pend = wr_go;
                    if (wr_go) begin
                        next_st.wr_col = col;
                    end
                    if (st.wr_pend) begin
                        next_st.mem[st.wr_col] = mrg_rise;
                        next_st.mem[wcol_nx]   = mrg_fall;
                    end
                    // Read latency countdown; masks not consulted here
                    if (rd_go) begin
                        next_st.rd_cnt = (cl == CL_THREE) ? 2'h2 : 2'h1;
                        next_st.rd_col = col;
                    end else if (st.rd_cnt != 2'h0) begin
                        next_st.rd_cnt = st.rd_cnt - 2'h1;
                    end
                    if (st.rd_cnt == 2'h1) begin
                        // Data and strobe launched on the same edge
                        next_st.dq_rise = st.mem[st.rd_col];
                        next_st.dq_fall = st.mem[COL_W'(st.rd_col + 1'b1)];
                        next_st.dq_oe   = 1'b1;
                    end
                end
            end
            ST_DPD: begin
                // Leave on clock enable high; controller waits before commands
                if (cke) begin
                    next_st.state = ST_RUN;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st       <= '0;
            st.state <= ST_RUN;
            st.mr    <= MR_RST;
            st.emr   <= EMR_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign dq_rise              = st.dq_rise;
    assign dq_fall              = st.dq_fall;
    assign dq_oe                = st.dq_oe;
    assign dqs_oe               = st.dq_oe;
    assign deep_power_down      = (st.state == ST_DPD);
    assign initialized          = st.mr_ok && st.emr_ok;
    assign read_latency_setting = cl;

    // Helpers for the checks below
    logic [7:0]  old_b0;   // Byte 0 at write column
    logic [31:0] old_w0;   // Word at write column
    assign old_b0 = st.mem[st.wr_col][7:0];
    assign old_w0 = st.mem[st.wr_col];

    a_dpd_wipe: assert property (@(posedge clk) disable iff (!rstn)
        dpd_entry |=> (st.mem == '0) && deep_power_down)
        else $error("array not cleared on deep power-down");

    a_mr_lost: assert property (@(posedge clk) disable iff (!rstn)
        dpd_entry |=> !initialized && st.mr == MR_RST && st.emr == EMR_RST)
        else $error("mode registers kept across deep power-down");

    a_rd_cl3: assert property (@(posedge clk) disable iff (!rstn)
        rd_go && cl == CL_THREE |-> !dq_oe ##1 !dq_oe ##1 !dq_oe ##1 dq_oe)
        else $error("latency three data not two clocks after read");

    a_rd_cl2: assert property (@(posedge clk) disable iff (!rstn)
        rd_go && cl == CL_TWO |-> ##2 dq_oe)
        else $error("latency two data not one clock after read");

    a_dq_strobe: assert property (@(posedge clk) disable iff (!rstn)
        $changed(dq_rise) || $changed(dq_fall) |-> dqs_oe)
        else $error("data changed without strobe");

    a_rd_nomask: assert property (@(posedge clk) disable iff (!rstn)
        !st.wr_pend && !dpd_entry |=> $stable(st.mem))
        else $error("array changed outside a write");

    a_wr_allmask: assert property (@(posedge clk) disable iff (!rstn)
        st.wr_pend && !dpd_entry && (&dm_rise) |=> st.mem[$past(st.wr_col)] == $past(old_w0))
        else $error("masked beat altered data");

    a_lane0_map: assert property (@(posedge clk) disable iff (!rstn)
        st.wr_pend && !dpd_entry && dm_rise[0] && !dm_rise[1]
        |=> st.mem[$past(st.wr_col)][7:0] == $past(old_b0)
            && st.mem[$past(st.wr_col)][15:8] == $past(wdata_rise[15:8]))
        else $error("mask lane zero mapped to wrong byte");

    a_emr_sel: assert property (@(posedge clk) disable iff (!rstn)
        mrs_go && ba == BA_EMR |=> st.emr == $past(addr) && $stable(st.mr))
        else $error("extended mode register not selected");
endmodule
`default_nettype wire

// ==== hw/lpi_pkg.sv ====
// Shared constants for the low-power DDR power and initialization block
`default_nettype none
package lpi_pkg;
    // Command codes on {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // Bank address selects for mode register set
    localparam logic [1:0] BA_MR   = 2'h0;
    localparam logic [1:0] BA_EMR  = 2'h2;
    // Read latency field of the base mode register
    localparam int         MR_CL_LSB = 4;
    localparam int         MR_CL_W   = 3;
    localparam logic [2:0] CL_TWO    = 3'h2;
    localparam logic [2:0] CL_THREE  = 3'h3;
    // Mode register reset contents
    localparam logic [11:0] MR_RST   = 12'h000;
    localparam logic [11:0] EMR_RST  = 12'h000;
    // Bus widths
    localparam int DATA_W  = 32;
    localparam int LANES   = 4;
    localparam int ADDR_W  = 12;
    // Device state, one-hot
    typedef enum logic [1:0] {
        ST_RUN = 2'h1,
        ST_DPD = 2'h2
    } lpi_state_t;
endpackage
`default_nettype wire

// ==== hw/lpi_byte_merge.sv ====
// Byte-lane write merge under a per-lane mask
`default_nettype none
module lpi_byte_merge #(
    parameter int LANES = 4
) (
    // Stored and incoming words
    input  wire logic [LANES*8-1:0] old_word,
    input  wire logic [LANES*8-1:0] new_word,
    // High keeps the stored byte
    input  wire logic [LANES-1:0]   mask,
    // Merged result
    output logic      [LANES*8-1:0] merged
);
    // One multiplexer per byte lane; lane i covers bits 8i..8i+7
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign merged[i*8 +: 8] = mask[i] ? old_word[i*8 +: 8] : new_word[i*8 +: 8];
    end
endmodule
`default_nettype wire

// ==== test/lpi_ctrl_model.sv ====
// Memory controller model driving command bus and write beats
`default_nettype none
module lpi_ctrl_model
    import lpi_pkg::*;
#(
    parameter int WAIT_CYC = 40000, // 200us of clocks
    parameter int T_RP     = 4,     // Row precharge wait
    parameter int T_RFC    = 16,    // Refresh cycle wait
    parameter int T_MRD    = 2      // Mode-set wait
) (
    // Clock
    input  wire logic              clk,
    // Command bus
    output var logic               cke,
    output var logic               cs_n,
    output var logic               ras_n,
    output var logic               cas_n,
    output var logic               we_n,
    output var logic [1:0]         ba,
    output var logic [ADDR_W-1:0]  addr,
    // Write beats and masks
    output var logic [DATA_W-1:0]  wdata_rise,
    output var logic [DATA_W-1:0]  wdata_fall,
    output var logic [LANES-1:0]   dm_rise,
    output var logic [LANES-1:0]   dm_fall
);
    timeunit 1ns;
    timeprecision 100ps;
    // Enable high from the start, before clock use
    initial begin
        cke = 1'b1;
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = CMD_NOP;
        ba = 2'h0;
        addr = '0;
        wdata_rise = '0;
        wdata_fall = '0;
        dm_rise = 4'hF;
        dm_fall = 4'hF;
    end
    // One command for one clock, then no-op
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
        @(posedge clk);
        #1;
        {ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(posedge clk);
        #1;
        {ras_n, cas_n, we_n} = CMD_NOP;
        addr = ~a;
    endtask
    // Command with chip select high; the device must ignore it
    task automatic issue_desel(input logic [2:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
        @(posedge clk);
        #1;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = CMD_NOP;
        addr = ~a;
    endtask
    // No-ops for n clocks
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Full init with chosen latency and extended select
    task automatic init(input logic [2:0] lat, input logic [1:0] eba);
        idle(WAIT_CYC);
        issue(CMD_PRE, 2'h0, 12'h400);
        idle(T_RP);
        repeat (2) begin
            issue(CMD_REF, 2'h0, 12'h000);
            idle(T_RFC);
        end
        issue(CMD_MRS, BA_MR, {5'h00, lat, 4'h0});
        idle(T_MRD);
        issue(CMD_MRS, eba, 12'h000);
        idle(T_MRD);
    endtask
    // Write with both beats and masks
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] r, input logic [DATA_W-1:0] f,
                         input logic [LANES-1:0] mr, input logic [LANES-1:0] mf);
        issue(CMD_WR, 2'h0, a);
        wdata_rise = r;
        wdata_fall = f;
        dm_rise = mr;
        dm_fall = mf;
        @(posedge clk);
        #1;
        wdata_rise = ~r;
        wdata_fall = ~f;
        dm_rise = 4'hF;
        dm_fall = 4'hF;
    endtask
    // Idle banks, then drop enable with the entry command
    task automatic dpd_enter();
        issue(CMD_PRE, 2'h0, 12'h400);
        idle(T_RP);
        @(posedge clk);
        #1;
        cke = 1'b0;
        {ras_n, cas_n, we_n} = CMD_BST;
        @(posedge clk);
        #1;
        {ras_n, cas_n, we_n} = CMD_NOP;
    endtask
    // Raise enable with clock already running
    task automatic dpd_exit();
        @(posedge clk);
        #1;
        cke = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the device block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import lpi_pkg::*;
    // Clock, reset and counters
    logic clk = 1'b0;
    logic clk_run = 1'b1;
    logic rstn;
    int   error_cnt = 0;
    int   samples_checked = 0;
    // Bus between model and device
    logic cke, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_oe, deep_power_down, initialized;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata_rise, wdata_fall, dq_rise, dq_fall;
    logic [LANES-1:0] dm_rise, dm_fall;
    logic [MR_CL_W-1:0] read_latency_setting;
    // Clock parks low while stopped
    always #2.5 clk = clk_run ? ~clk : 1'b0;
    lpi_ctrl_model #(.WAIT_CYC(400)) i_lpi_ctrl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .wdata_rise(wdata_rise), .wdata_fall(wdata_fall),
        .dm_rise(dm_rise), .dm_fall(dm_fall));
    lpi_device #(.MEM_WORDS(16)) i_lpi_device (.clk(clk), .rstn(rstn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .wdata_rise(wdata_rise), .wdata_fall(wdata_fall),
        .dm_rise(dm_rise), .dm_fall(dm_fall), .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe(dq_oe),
        .dqs_oe(dqs_oe), .deep_power_down(deep_power_down), .initialized(initialized),
        .read_latency_setting(read_latency_setting));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Read, check valid pulse timing and both beats
    task automatic read_chk(input logic [ADDR_W-1:0] a, input int lat, input logic [31:0] er, input logic [31:0] ef);
        i_lpi_ctrl_model.issue(CMD_RD, 2'h0, a);
        for (int k = 1; k <= 4; k++) begin
            chk(32'(dq_oe), 32'(k == lat));
            chk(32'(dqs_oe), 32'(dq_oe));
            @(posedge clk);
            #1;
        end
        chk(dq_rise, er);
        chk(dq_fall, ef);
    endtask
    // Power-up init
    task automatic t_init();
        i_lpi_ctrl_model.init(CL_THREE, BA_EMR);
        chk(32'(initialized), 32'h0000_0001);
        chk(32'(read_latency_setting), 32'h0000_0003);
    endtask
    // Each mask lane on each beat
    task automatic t_mask();
        logic [31:0] er, ef;
        for (int i = 0; i < 4; i++) begin
            i_lpi_ctrl_model.write(12'h002, 32'hA5A5_A5A5, 32'h5A5A_5A5A, 4'h0, 4'h0);
            i_lpi_ctrl_model.write(12'h002, 32'hFFFF_FFFF, 32'h0000_0000, ~(4'h1 << i), 4'h1 << i);
            er = 32'hA5A5_A5A5;
            ef = 32'h0000_0000;
            er[8*i +: 8] = 8'hFF;
            ef[8*i +: 8] = 8'h5A;
            read_chk(12'h002, 3, er, ef);
        end
    endtask
    // Latency two, then back to three
    task automatic t_latency();
        i_lpi_ctrl_model.issue(CMD_MRS, BA_MR, {5'h00, CL_TWO, 4'h0});
        i_lpi_ctrl_model.idle(2);
        chk(32'(read_latency_setting), 32'h0000_0002);
        read_chk(12'h002, 2, 32'hFFA5_A5A5, 32'h5A00_0000);
        i_lpi_ctrl_model.issue(CMD_MRS, BA_MR, {5'h00, CL_THREE, 4'h0});
        i_lpi_ctrl_model.idle(2);
    endtask
    // Stop and restart clock, data kept
    task automatic t_clock_stop();
        i_lpi_ctrl_model.write(12'h005, 32'h1234_5678, 32'h9ABC_DEF0, 4'h0, 4'h0);
        i_lpi_ctrl_model.write(12'h005, 32'h0000_0000, 32'h0F0F_0F0F, 4'hF, 4'h0);
        i_lpi_ctrl_model.idle(2);
        #1;
        clk_run = 1'b0;
        #100;
        clk_run = 1'b1;
        i_lpi_ctrl_model.idle(1);
        read_chk(12'h005, 3, 32'h1234_5678, 32'h0F0F_0F0F);
    endtask
    // Deselected commands are ignored
    task automatic t_deselect();
        i_lpi_ctrl_model.issue_desel(CMD_MRS, BA_MR, {5'h00, CL_TWO, 4'h0});
        i_lpi_ctrl_model.issue_desel(CMD_RD, 2'h0, 12'h002);
        for (int k = 1; k <= 3; k++) begin
            chk(32'(dq_oe), 32'h0000_0000);
            @(posedge clk);
            #1;
        end
        chk(32'(read_latency_setting), 32'h0000_0003);
    endtask
    // Mid-run reset clears status and the read output enable
    task automatic t_reset();
        @(posedge clk);
        #1;
        rstn = 1'b0;
        #1;
        chk(32'(initialized), 32'h0000_0000);
        chk(32'(read_latency_setting), 32'h0000_0000);
        chk(32'(deep_power_down | dq_oe), 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        i_lpi_ctrl_model.idle(2);
        chk(32'(initialized), 32'h0000_0000);
    endtask
    // Deep power-down wipes array and mode registers
    task automatic t_dpd();
        i_lpi_ctrl_model.dpd_enter();
        chk(32'(deep_power_down), 32'h0000_0001);
        chk(32'(initialized), 32'h0000_0000);
        chk(32'(read_latency_setting), 32'h0000_0000);
        i_lpi_ctrl_model.dpd_exit();
        i_lpi_ctrl_model.init(CL_THREE, 2'h1);
        chk(32'(deep_power_down), 32'h0000_0000);
        chk(32'(initialized), 32'h0000_0000);
        i_lpi_ctrl_model.issue(CMD_MRS, BA_EMR, 12'h000);
        i_lpi_ctrl_model.idle(2);
        chk(32'(initialized), 32'h0000_0001);
        read_chk(12'h002, 3, 32'h0000_0000, 32'h0000_0000);
        read_chk(12'h005, 3, 32'h0000_0000, 32'h0000_0000);
    endtask
    // Main sequence
    initial begin
        rstn = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_init();
        t_mask();
        t_latency();
        t_deselect();
        t_clock_stop();
        t_dpd();
        t_reset();
        final_report();
    end
    // Watchdog
    initial begin
        #50000;
        error_cnt++;
        final_report();
    end
endmodule
`default_nettype wire
